/* File: logic/cfgh_dec_if.sv */
// carrier between the header registers and the memory window decoder
`timescale 1ns/1ps
interface cfgh_dec_if;
  logic [31:0] addr;     // memory cycle address
  logic [11:0] base;     // stored window base bits
  logic        mem_en;   // memory space enable
  logic        hit;      // address falls in the window
  modport dec  (input addr, input base, input mem_en, output hit);
  modport regs (output addr, output base, output mem_en, input hit);
endinterface

/* File: logic/cfgh_defines.svh */
// offsets, field positions, reset values and fixed patterns of the header
`ifndef CFGH_DEFINES_SVH
`define CFGH_DEFINES_SVH
// byte offsets of the header words
`define CFGH_OFS_ID        8'h00
`define CFGH_OFS_CMD       8'h04
`define CFGH_OFS_BAR       8'h10
`define CFGH_OFS_RSVD_LO   8'h14
`define CFGH_OFS_RSVD_HI   8'h38
`define CFGH_OFS_INTR      8'h3C
`define CFGH_OFS_HDR_END   8'h40
// command / status field positions
`define CFGH_CMD_MEM_BIT   1
`define CFGH_CMD_PERR_BIT  6
`define CFGH_STAT_DPE_BIT  31
// base address register layout
`define CFGH_BAR_LSB       20
`define CFGH_BAR_MSB       31
`define CFGH_BAR_RST       12'h000
// latency, grant and interrupt word
`define CFGH_MAX_LAT       8'h0F
`define CFGH_MIN_GNT       8'h00
`define CFGH_INT_PIN       8'h01
`define CFGH_INT_LINE_RST  8'h00
// second function storage
`define CFGH_F1_WORDS      16
`define CFGH_F1_RST        32'h0000_0000
`endif

/* File: logic/cfgh_pkg.sv */
// types shared by the configuration header design
package cfgh_pkg;
  // which function a configuration cycle addresses
  typedef enum logic {CFGH_FN0, CFGH_FN1} cfgh_func_t;
  // configuration access sequencing
  typedef enum logic {CFGH_IDLE, CFGH_RESP} cfgh_acc_t;
endpackage

/* File: logic/cfgh_top.sv */
// configuration header registers and memory window claim of the controller
`timescale 1ns/1ps
`include "cfgh_defines.svh"

// Summary of operation
// R1 - claim memory cycle on base match, enabled
// R2 - unimplemented window locations read zero, ignore writes
// R3 - base bits 19:4 hardwired zero, 1 MB
// R4 - base bit 3 reads zero, not prefetchable
// R5 - base bits 2:1 read zero, anywhere
// R6 - base bit 0 reads zero, memory space
// R7 - words 14h to 38h reserved, zero
// R8 - maximum latency field reads constant 0Fh
// R9 - minimum grant field reads zero
// R10 - interrupt pin field reads constant 01h
// R11 - interrupt line held for readback, resets zero
// R12 - device-dependent region reads zero, ignores writes
// R13 - read-only fields return fixed pattern always
// R14 - write-one clears sticky status, zero keeps
// R15 - read/write fields return last written value
// R16 - second function has sixteen header words
// R17 - memory space enable gates window response
// R18 - reset restores fields, byte enables mask writes
module cfgh_top #(
  parameter logic [15:0] VENDOR_CODE = 16'h0A5A,  // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h1234,  // arbitrary value
  parameter int          F1_WORDS    = `CFGH_F1_WORDS
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_b,
  input  wire logic                cfg_req,
  input  wire logic                cfg_wr,
  input  wire cfgh_pkg::cfgh_func_t cfg_func,
  input  wire logic [7:0]          cfg_addr,
  input  wire logic [3:0]          cfg_be,
  input  wire logic [31:0]         cfg_wdata,
  output logic                     cfg_ack,
  output logic      [31:0]         cfg_rdata,
  input  wire logic                par_err_evt,
  input  wire logic                mem_req,
  input  wire logic                mem_wr,
  input  wire logic [31:0]         mem_addr,
  input  wire logic                mem_impl,
  input  wire logic [31:0]         mem_core_rdata,
  output logic                     mem_claim,
  output logic                     mem_core_wr,
  output logic                     mem_ack,
  output logic      [31:0]         mem_rdata,
  output logic                     mem_space_en,
  output logic                     perr_resp_en
);
  import cfgh_pkg::*;

  // the second function is addressed by a four-bit word index
  if (F1_WORDS != 16) begin : g_chk_words
    $error("second function must have exactly sixteen words");
  end

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_s1_r;     // first stage of reset release
  logic rst_n_sync;   // released reset used by everything else

  // rst_b may drop at any moment, but its release is retimed so that no
  // flop leaves reset on a different edge from its neighbours; the cost
  // is two cycles of extra latency after the pin goes high

  // assertion is asynchronous, release waits two edges
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r   <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1_r   <= 1'b1;
      rst_n_sync <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------------
  // access decode
  // ------------------------------------------------------------------
  logic       in_header;   // offset inside the 64-byte header
  logic       f0_wr;       // write to the first function
  logic       f1_wr;       // write to the second function
  logic [7:0] ofs;         // dword aligned byte offset

  // the two low address bits never select anything: every access is a
  // whole dword, narrowed only by the byte enables

  always_comb begin
    ofs       = {cfg_addr[7:2], 2'b00};
    // the upper 192 bytes are never decoded; see R12
    in_header = (ofs < `CFGH_OFS_HDR_END);
    f0_wr     = cfg_req && cfg_wr && in_header && (cfg_func == CFGH_FN0);
    f1_wr     = cfg_req && cfg_wr && in_header && (cfg_func == CFGH_FN1);
  end

  // ------------------------------------------------------------------
  // first function read/write state
  // ------------------------------------------------------------------
  logic        mem_en_r;      // command: memory space enable
  logic        mem_en_nxt;
  logic        perr_en_r;     // command: parity error response
  logic        perr_en_nxt;
  logic        dpe_r;         // status: detected parity error
  logic        dpe_nxt;
  logic [11:0] bar_r;         // window base bits 31:20
  logic [11:0] bar_nxt;
  logic [7:0]  int_line_r;    // interrupt line routing byte
  logic [7:0]  int_line_nxt;

  // the parity flag is the only state that hardware sets on its own;
  // giving the event priority means an error arriving while software
  // clears an older one is still reported afterwards

  // byte lanes only update where enabled; see R18
  always_comb begin
    mem_en_nxt   = mem_en_r;
    perr_en_nxt  = perr_en_r;
    dpe_nxt      = dpe_r;
    bar_nxt      = bar_r;
    int_line_nxt = int_line_r;
    // command byte holds both writable control bits
    if (f0_wr && (ofs == `CFGH_OFS_CMD) && cfg_be[0]) begin
      mem_en_nxt  = cfg_wdata[`CFGH_CMD_MEM_BIT];    // see R15
      perr_en_nxt = cfg_wdata[`CFGH_CMD_PERR_BIT];   // see R15
    end
    // writing one clears, writing zero keeps; see R14
    if (f0_wr && (ofs == `CFGH_OFS_CMD) && cfg_be[3] &&
        cfg_wdata[`CFGH_STAT_DPE_BIT]) begin
      dpe_nxt = 1'b0;
    end
    // a new error in the clearing cycle must not be lost
    if (par_err_evt) begin
      dpe_nxt = 1'b1;   // see R14
    end
    // only bits 31:20 of the base are storage; see R3
    if (f0_wr && (ofs == `CFGH_OFS_BAR)) begin
      if (cfg_be[2]) begin
        bar_nxt[3:0] = cfg_wdata[23:20];    // see R15
      end
      if (cfg_be[3]) begin
        bar_nxt[11:4] = cfg_wdata[31:24];   // see R15
      end
    end
    // interrupt line is the single writable byte here
    if (f0_wr && (ofs == `CFGH_OFS_INTR) && cfg_be[0]) begin
      int_line_nxt = cfg_wdata[7:0];   // see R11
    end
  end

  // register the first function state
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      // reset values; see R18, see R11
      mem_en_r   <= 1'b0;
      perr_en_r  <= 1'b0;
      dpe_r      <= 1'b0;
      bar_r      <= `CFGH_BAR_RST;
      int_line_r <= `CFGH_INT_LINE_RST;
    end else begin
      mem_en_r   <= mem_en_nxt;
      perr_en_r  <= perr_en_nxt;
      dpe_r      <= dpe_nxt;
      bar_r      <= bar_nxt;
      int_line_r <= int_line_nxt;
    end
  end

  // ------------------------------------------------------------------
  // second function storage
  // ------------------------------------------------------------------
  logic [31:0] f1_rdata_r;   // registered read of the second function

  // the store reads every cycle with whatever index is on the address;
  // only the value captured at the request edge is ever shown

  // sixteen dword header of its own; see R16
  cfgh_word_mem #(
    .WORDS (F1_WORDS)
  ) u_f1_mem (
    .clk_sys    (clk_sys),
    .rst_n_sync (rst_n_sync),
    .wr_en      (f1_wr),
    .idx        (cfg_addr[5:2]),
    .be         (cfg_be),
    .wdata      (cfg_wdata),
    .rdata_r    (f1_rdata_r)
  );

  // ------------------------------------------------------------------
  // first function read mux
  // ------------------------------------------------------------------
  logic [31:0] f0_word;   // word selected for a read

  // the identity word is fixed by parameters and ignores writes; the two
  // words after the command word read zero in this block

  // unused and reserved bits read zero whatever was written
  always_comb begin
    f0_word = 32'h0000_0000;
    if (in_header) begin
      if (ofs == `CFGH_OFS_ID) begin
        f0_word = {DEVICE_CODE, VENDOR_CODE};   // see R13
      end else if (ofs == `CFGH_OFS_CMD) begin
        f0_word[`CFGH_STAT_DPE_BIT] = dpe_r;
        f0_word[`CFGH_CMD_PERR_BIT] = perr_en_r;
        f0_word[`CFGH_CMD_MEM_BIT]  = mem_en_r;
      end else if (ofs == `CFGH_OFS_BAR) begin
        // low bits stay zero: 1 MB, non-prefetch, 32-bit, memory
        // see R3, see R4, see R5, see R6
        f0_word[`CFGH_BAR_MSB:`CFGH_BAR_LSB] = bar_r;
      end else if ((ofs >= `CFGH_OFS_RSVD_LO) &&
                   (ofs <= `CFGH_OFS_RSVD_HI)) begin
        f0_word = 32'h0000_0000;   // see R7
      end else if (ofs == `CFGH_OFS_INTR) begin
        f0_word = {`CFGH_MAX_LAT,     // see R8
                   `CFGH_MIN_GNT,     // see R9
                   `CFGH_INT_PIN,     // see R10
                   int_line_r};       // see R11
      end
    end
  end

  // ------------------------------------------------------------------
  // configuration answer sequencing
  // ------------------------------------------------------------------
  cfgh_acc_t   acc_r;        // idle or answering
  cfgh_acc_t   acc_nxt;
  logic        sel_f1_r;     // answer comes from the second function
  logic        sel_f1_nxt;
  logic        hdr_r;        // request hit the implemented header
  logic        hdr_nxt;
  logic [31:0] f0_rdata_r;   // registered first function read data
  logic [31:0] f0_rdata_nxt;

  // a request seen while answering gets no answer of its own: the host
  // must wait for cfg_ack before it asks again

  // every request taken while idle is answered exactly one edge later
  always_comb begin
    acc_nxt      = CFGH_IDLE;
    sel_f1_nxt   = sel_f1_r;
    hdr_nxt      = hdr_r;
    f0_rdata_nxt = f0_rdata_r;
    unique case (acc_r)
      CFGH_IDLE: begin
        if (cfg_req) begin
          acc_nxt      = CFGH_RESP;
          sel_f1_nxt   = (cfg_func == CFGH_FN1);
          hdr_nxt      = in_header;
          f0_rdata_nxt = f0_word;
        end
      end
      CFGH_RESP: begin
        // a request here is refused by the host protocol
        acc_nxt = CFGH_IDLE;
      end
    endcase
  end

  // register the sequencing state
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      acc_r      <= CFGH_IDLE;
      sel_f1_r   <= 1'b0;
      hdr_r      <= 1'b0;
      f0_rdata_r <= 32'h0000_0000;
    end else begin
      acc_r      <= acc_nxt;
      sel_f1_r   <= sel_f1_nxt;
      hdr_r      <= hdr_nxt;
      f0_rdata_r <= f0_rdata_nxt;
    end
  end

  // answer mux picks between two registered sources
  always_comb begin
    cfg_ack   = (acc_r == CFGH_RESP);
    cfg_rdata = 32'h0000_0000;
    if (cfg_ack && hdr_r) begin
      cfg_rdata = sel_f1_r ? f1_rdata_r : f0_rdata_r;
    end else if (cfg_ack) begin
      cfg_rdata = 32'h0000_0000;   // see R12
    end
  end

  // ------------------------------------------------------------------
  // memory window
  // ------------------------------------------------------------------
  cfgh_dec_if dec_bus ();   // decoder connection

  // an unassigned window (base all zero) never claims, so a host that
  // enables memory space before placing the base sees no stray claims

  always_comb begin
    dec_bus.addr   = mem_addr;
    dec_bus.base   = bar_r;
    dec_bus.mem_en = mem_en_r;   // see R17
  end

  cfgh_win_dec u_dec (
    .d (dec_bus.dec)
  );

  logic        mack_r;       // memory answer strobe
  logic        mack_nxt;
  logic [31:0] mrdata_r;     // memory read data
  logic [31:0] mrdata_nxt;

  // the core is asked for data on every claimed read; locations it does
  // not implement read zero here, so stale core data never leaks out

  // claim is combinational so the target answers in the address phase
  always_comb begin
    mem_claim   = mem_req && dec_bus.hit;   // see R1
    // writes reach the core only where a location exists; see R2
    mem_core_wr = mem_claim && mem_wr && mem_impl;
    mack_nxt    = mem_claim;
    mrdata_nxt  = 32'h0000_0000;
    if (mem_claim && !mem_wr && mem_impl) begin
      mrdata_nxt = mem_core_rdata;
    end else if (mem_claim) begin
      mrdata_nxt = 32'h0000_0000;   // see R2
    end
  end

  // register the memory answer
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      mack_r   <= 1'b0;
      mrdata_r <= 32'h0000_0000;
    end else begin
      mack_r   <= mack_nxt;
      mrdata_r <= mrdata_nxt;
    end
  end

  // control levels out to the rest of the controller
  always_comb begin
    mem_ack      = mack_r;
    mem_rdata    = mrdata_r;
    mem_space_en = mem_en_r;
    perr_resp_en = perr_en_r;
  end
endmodule

/* File: logic/cfgh_win_dec.sv */
// 1 MB memory window decoder for one function
`timescale 1ns/1ps
module cfgh_win_dec (
  cfgh_dec_if.dec d
);
  import cfgh_pkg::*;

  // an all-zero base means unassigned, so it never claims a cycle
  logic base_set;

  always_comb begin
    base_set = |d.base;
    // see R1, see R17
    d.hit = d.mem_en && base_set &&
            (d.addr[31:20] == d.base);
  end
endmodule

/* File: logic/cfgh_word_mem.sv */
// small word store with byte writes and registered read data
`timescale 1ns/1ps
`include "cfgh_defines.svh"
module cfgh_word_mem #(
  parameter int WORDS = 16
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n_sync,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] idx,
  input  wire logic [3:0]               be,
  input  wire logic [31:0]              wdata,
  output logic      [31:0]              rdata_r
);
  import cfgh_pkg::*;

  // a single word would leave the index without any bits
  if (WORDS < 2) begin : g_chk_words
    $error("word store needs at least two words");
  end

  logic [31:0] word_r   [WORDS];   // stored words
  logic [31:0] word_nxt [WORDS];   // next stored words
  logic [31:0] rdata_nxt;          // next read data

  // only enabled byte lanes change; see R18
  always_comb begin
    for (int w = 0; w < WORDS; w++) begin
      word_nxt[w] = word_r[w];
      for (int b = 0; b < 4; b++) begin
        if (wr_en && be[b] && (idx == w[$clog2(WORDS)-1:0])) begin
          word_nxt[w][8*b +: 8] = wdata[8*b +: 8];   // see R15
        end
      end
    end
    rdata_nxt = word_r[idx];
  end

  // register the store and the read port
  always_ff @(posedge clk_sys or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      for (int w = 0; w < WORDS; w++) begin
        word_r[w] <= `CFGH_F1_RST;
      end
      rdata_r <= 32'h0000_0000;
    end else begin
      word_r  <= word_nxt;
      rdata_r <= rdata_nxt;
    end
  end
endmodule

/* File: tb/cfgh_host_model.sv */
// host side model: issues configuration and memory cycles
`timescale 1ns/1ps
module cfgh_host_model
  import cfgh_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             cfg_req,
  output logic             cfg_wr,
  output cfgh_func_t       cfg_func,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  input  wire logic        cfg_ack,
  input  wire logic [31:0] cfg_rdata,
  output logic             par_err_evt,
  output logic             mem_req,
  output logic             mem_wr,
  output logic [31:0]      mem_addr,
  output logic             mem_impl,
  output logic [31:0]      mem_core_rdata,
  input  wire logic        mem_claim,
  input  wire logic        mem_core_wr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  // quiet bus at time zero
  initial begin
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = '0;
    cfg_func = CFGH_FN0;
    {par_err_evt, mem_req, mem_wr, mem_addr, mem_impl} = '0;
    mem_core_rdata = '0;
  end
  // one config cycle; answer is taken in the cycle after the request
  task cfg_acc(input logic w, input cfgh_func_t f, input logic [7:0] a,
               input logic [3:0] be, input logic [31:0] d,
               output logic ok, output logic [31:0] rd);
    @(posedge clk_sys);
    #1;
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, be, d};
    cfg_func = f;
    @(posedge clk_sys);
    #1;
    cfg_req = 1'b0;
    cfg_addr = ~a;   // released address and data lines never keep the old value
    cfg_wdata = ~d;
    ok = cfg_ack;
    rd = cfg_rdata;
  endtask
  // one memory cycle; claim seen at once, ack one cycle later
  task mem_acc(input logic w, input logic [31:0] a, input logic impl,
               output logic cl, output logic cw, output logic ak,
               output logic [31:0] rd);
    @(posedge clk_sys);
    #1;
    {mem_req, mem_wr, mem_addr, mem_impl} = {1'b1, w, a, impl};
    mem_core_rdata = 32'hC0DE_0001;
    #1;
    cl = mem_claim;
    cw = mem_core_wr;
    @(posedge clk_sys);
    #1;
    mem_req = 1'b0;
    mem_addr = ~a;
    mem_core_rdata = 32'h3F21_FFFE;
    ak = mem_ack;
    rd = mem_rdata;
  endtask
  // single parity error event
  task perr;
    @(posedge clk_sys);
    #1;
    par_err_evt = 1'b1;
    @(posedge clk_sys);
    #1;
    par_err_evt = 1'b0;
  endtask
endmodule

/* File: tb/cfgh_top_properties.sv */
// port-level assertions for the configuration header block
`timescale 1ns/1ps
module cfgh_top_properties
  import cfgh_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        cfg_req,
  input wire logic        cfg_wr,
  input wire cfgh_func_t  cfg_func,
  input wire logic [7:0]  cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic        cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic        mem_req,
  input wire logic        mem_wr,
  input wire logic        mem_impl,
  input wire logic        mem_claim,
  input wire logic        mem_core_wr,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic        mem_space_en
);
  // taken first-function read and write, word index of the address
  wire       rd0 = cfg_req && !cfg_wr && !cfg_ack && cfg_func == CFGH_FN0;
  wire       wr0 = cfg_req && cfg_wr && cfg_func == CFGH_FN0;
  wire [5:0] adr = cfg_addr[7:2];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_claim_gate: assert property (
    mem_claim |-> mem_req && mem_space_en) else $error("claim not gated");
  a_claim_ack: assert property (
    mem_claim |=> mem_ack) else $error("claim without ack");
  a_ack_cause: assert property (
    mem_ack |-> $past(mem_claim)) else $error("ack without claim");
  a_unimpl_zero: assert property (
    mem_claim && !mem_wr && !mem_impl |=> mem_rdata == 32'h0)
    else $error("unimplemented read not zero");
  a_core_write: assert property (
    mem_core_wr == (mem_claim && mem_wr && mem_impl))
    else $error("core write mismatch");
  a_cfg_answer: assert property (
    cfg_req && !cfg_ack |=> cfg_ack) else $error("config not answered");
  a_bar_low: assert property (
    rd0 && adr == 6'h04 |=> cfg_rdata[19:0] == 20'h0)
    else $error("base low bits not zero");
  a_lat_word: assert property (
    rd0 && adr == 6'h0F |=> cfg_rdata[31:8] == 24'h0F0001)
    else $error("latency word wrong");
  a_rsvd_zero: assert property (
    rd0 && (adr inside {[6'h05:6'h0E]} || adr >= 6'h10) |=> cfg_rdata == 0)
    else $error("reserved word not zero");
  a_mem_enable: assert property (
    wr0 && adr == 6'h01 && cfg_be[0] |=> mem_space_en == $past(cfg_wdata[1]))
    else $error("memory enable not written");
  c_claim_wr: cover property (mem_claim && mem_wr);
  c_lat_read: cover property (rd0 && adr == 6'h0F);
  c_enable: cover property ($rose(mem_space_en));
endmodule

bind cfgh_top cfgh_top_properties u_props (.clk_sys, .rst_b, .cfg_req,
  .cfg_wr, .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata,
  .mem_req, .mem_wr, .mem_impl, .mem_claim, .mem_core_wr, .mem_ack,
  .mem_rdata, .mem_space_en);

/* File: tb/tb_top.sv */
// self-checking bench for the configuration header block
`timescale 1ns/1ps
module tb_top;
  import cfgh_pkg::*;
  logic        clk_sys, rst_b;
  wire         cfg_req, cfg_wr, cfg_ack, par_err_evt, mem_req, mem_wr;
  wire         mem_impl, mem_claim, mem_core_wr, mem_ack;
  wire         mem_space_en, perr_resp_en;
  wire [7:0]   cfg_addr;
  wire [3:0]   cfg_be;
  wire [31:0]  cfg_wdata, cfg_rdata, mem_addr, mem_core_rdata, mem_rdata;
  cfgh_func_t  cfg_func;
  int          miscompares, compares, cycles, i;
  logic        ok, cl, cw, ak;
  logic [31:0] rdv;
  cfgh_top dut (.clk_sys, .rst_b, .cfg_req, .cfg_wr, .cfg_func, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .par_err_evt, .mem_req,
    .mem_wr, .mem_addr, .mem_impl, .mem_core_rdata, .mem_claim,
    .mem_core_wr, .mem_ack, .mem_rdata, .mem_space_en, .perr_resp_en);
  cfgh_host_model host (.clk_sys, .cfg_req, .cfg_wr, .cfg_func, .cfg_addr,
    .cfg_be, .cfg_wdata, .cfg_ack, .cfg_rdata, .par_err_evt, .mem_req,
    .mem_wr, .mem_addr, .mem_impl, .mem_core_rdata, .mem_claim,
    .mem_core_wr, .mem_ack, .mem_rdata);
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // config write and read, both must be answered
  task wr(input cfgh_func_t f, input logic [7:0] a, input logic [3:0] be,
          input logic [31:0] d);
    host.cfg_acc(1'b1, f, a, be, d, ok, rdv);
    chk({31'h0, ok}, 32'h1);
  endtask
  task rd(input cfgh_func_t f, input logic [7:0] a, input logic [31:0] e);
    host.cfg_acc(1'b0, f, a, 4'hF, 32'h0, ok, rdv);
    chk({31'h0, ok}, 32'h1);
    chk(rdv, e);
  endtask
  // memory cycle: claim, core write strobe, ack and read data
  task mem(input logic w, input logic [31:0] a, input logic impl,
           input logic ec, input logic ew, input logic [31:0] er);
    host.mem_acc(w, a, impl, cl, cw, ak, rdv);
    chk({29'h0, cl, cw, ak}, {29'h0, ec, ew, ec});
    chk(rdv, er);
  endtask
  task final_report;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // hang guard: whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    rst_b = 1'b0;
    repeat (12) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(CFGH_FN0, 8'h10, 32'h0);
    rd(CFGH_FN0, 8'h3C, 32'h0F00_0100);
    // identity word keeps its fixed pattern whatever is written
    wr(CFGH_FN0, 8'h00, 4'hF, 32'hFFFF_FFFF);
    rd(CFGH_FN0, 8'h00, 32'h1234_0A5A);
    wr(CFGH_FN0, 8'h10, 4'hF, 32'hFFFF_FFFF);
    rd(CFGH_FN0, 8'h10, 32'hFFF0_0000);
    wr(CFGH_FN0, 8'h10, 4'h8, 32'h12AB_CDEF);
    wr(CFGH_FN0, 8'h10, 4'h4, 32'h0030_0000);
    rd(CFGH_FN0, 8'h10, 32'h1230_0000);
    // reserved, unused and device-dependent words ignore writes
    for (i = 8'h14; i <= 8'hFC; i += 4) begin
      if (i != 8'h3C) begin
        wr(CFGH_FN0, i[7:0], 4'hF, 32'hFFFF_FFFF);
        rd(CFGH_FN0, i[7:0], 32'h0);
      end
    end
    wr(CFGH_FN0, 8'h3C, 4'hF, 32'hFFFF_FF5A);
    rd(CFGH_FN0, 8'h3C, 32'h0F00_015A);
    wr(CFGH_FN0, 8'h3C, 4'h0, 32'h0);
    rd(CFGH_FN0, 8'h3C, 32'h0F00_015A);
    mem(1'b0, 32'h1230_0010, 1'b1, 1'b0, 1'b0, 32'h0);
    wr(CFGH_FN0, 8'h04, 4'h1, 32'h0000_0042);
    chk({30'h0, mem_space_en, perr_resp_en}, 32'h3);
    mem(1'b0, 32'h1230_0010, 1'b1, 1'b1, 1'b0, 32'hC0DE_0001);
    mem(1'b0, 32'h123F_FFFC, 1'b0, 1'b1, 1'b0, 32'h0);
    mem(1'b1, 32'h1230_0020, 1'b1, 1'b1, 1'b1, 32'h0);
    mem(1'b1, 32'h1230_0024, 1'b0, 1'b1, 1'b0, 32'h0);
    mem(1'b0, 32'h1240_0000, 1'b1, 1'b0, 1'b0, 32'h0);
    // sticky parity status: a zero leaves it, a one clears it
    host.perr;
    rd(CFGH_FN0, 8'h04, 32'h8000_0042);
    wr(CFGH_FN0, 8'h04, 4'h8, 32'h0);
    rd(CFGH_FN0, 8'h04, 32'h8000_0042);
    wr(CFGH_FN0, 8'h04, 4'h8, 32'h8000_0000);
    rd(CFGH_FN0, 8'h04, 32'h0000_0042);
    // an error in the clearing cycle must survive the clear
    fork
      host.perr;
      wr(CFGH_FN0, 8'h04, 4'h8, 32'h8000_0000);
    join
    rd(CFGH_FN0, 8'h04, 32'h8000_0042);
    wr(CFGH_FN0, 8'h10, 4'hF, 32'h0);
    mem(1'b0, 32'h0000_0010, 1'b1, 1'b0, 1'b0, 32'h0);
    // second function: sixteen plain words, nothing beyond
    for (i = 0; i < 16; i++)
      wr(CFGH_FN1, 8'(i * 4), 4'hF, 32'h0101_0101 * i + 32'hA5);
    for (i = 0; i < 16; i++)
      rd(CFGH_FN1, 8'(i * 4), 32'h0101_0101 * i + 32'hA5);
    rd(CFGH_FN1, 8'h40, 32'h0);
    // reset in mid-run restores defaults
    wr(CFGH_FN0, 8'h10, 4'hF, 32'h5550_0000);
    @(posedge clk_sys);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(CFGH_FN0, 8'h10, 32'h0);
    rd(CFGH_FN0, 8'h04, 32'h0);
    rd(CFGH_FN0, 8'h3C, 32'h0F00_0100);
    rd(CFGH_FN1, 8'h3C, 32'h0);
    final_report;
  end
endmodule
